// *** rtl/spsb_pkg.sv ***
// Constants and types of the serial port buffer and status block
// Operation
// - Selector 111: interrupt when transmit buffer full
// - Selector 110: interrupt when transmit FIFO drains
// - Selector 101: interrupt when word fully shifted
// - Selector 100: interrupt when word enters shifter
// - Selector 011: interrupt when receive buffer full
// - Selector 010: interrupt at three-quarter receive fill
// - Selector 001: interrupt while receive data waits
// - Selector 000: interrupt when last entry read
// - Standard: data write loads holding, sets full
// - Standard: transfer to shifter clears transmit full
// - Enhanced: transmit full when last entry written
// - Enhanced: transmit full clears when entry frees
// - Standard: completed word sets receive full
// - Standard: data read returns word, clears full
// - Enhanced: receive full when last entry filled
// - Enhanced: receive full clears when entry frees
package spsb_pkg;

	localparam int ADDR_W     = 12;
	localparam int WORD_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_DEPTH = 2;

	localparam logic [ADDR_W-1:0] STAT_OFF = 12'h000;
	localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h004;
	localparam logic [ADDR_W-1:0] DATA_OFF = 12'h008;
	localparam logic [ADDR_W-1:0] ISTA_OFF = 12'h00c;
	localparam logic [ADDR_W-1:0] IMSK_OFF = 12'h010;

	localparam int EN_BIT     = 15;
	localparam int CNT_LSB    = 8;
	localparam int CNT_W      = 3;
	localparam int SR_MT_BIT  = 7;
	localparam int ROV_BIT    = 6;
	localparam int RX_MT_BIT  = 5;
	localparam int SEL_LSB    = 2;
	localparam int TBF_BIT    = 1;
	localparam int RBF_BIT    = 0;
	localparam int ENH_BIT    = 0;
	localparam int IRQ_BUF    = 0;
	localparam int IRQ_OVF    = 1;

	localparam logic [2:0] SEL_RESET  = 3'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;

	localparam logic [2:0] SEL_TX_FULL  = 3'h7;
	localparam logic [2:0] SEL_TX_EMPTY = 3'h6;
	localparam logic [2:0] SEL_TX_DONE  = 3'h5;
	localparam logic [2:0] SEL_TX_SPOT  = 3'h4;
	localparam logic [2:0] SEL_RX_FULL  = 3'h3;
	localparam logic [2:0] SEL_RX_3Q    = 3'h2;
	localparam logic [2:0] SEL_RX_AVAIL = 3'h1;
	localparam logic [2:0] SEL_RX_READ  = 3'h0;

	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
	} spsb_link_type;

	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] data;
	} spsb_word_type;

	typedef enum logic {
		ENG_IDLE,
		ENG_SHIFT
	} spsb_eng_type;

endpackage

// *** rtl/spsb_port.sv ***
// Serial port buffers, status, interrupt select and APB slave
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spsb_port
	import spsb_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int W     = WORD_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              sck,
	input  wire logic              sdi,
	input  wire logic              ss_n,
	output logic                   sdo,
	output logic                   sdo_oe,
	output logic                   irq
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] off);
		hit = (paddr == off);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic          en_reg;
	logic          enh_reg;
	logic [2:0]    sel_reg;
	logic          rov_reg;
	logic [1:0]    ista_reg;
	logic [1:0]    imsk_reg;
	logic [W-1:0]  tx_mem [DEPTH];
	logic [W-1:0]  rx_mem [DEPTH];
	logic [PW-1:0] tx_wp_reg;
	logic [PW-1:0] tx_rp_reg;
	logic [CW-1:0] tx_cnt_reg;
	logic [PW-1:0] rx_wp_reg;
	logic [PW-1:0] rx_rp_reg;
	logic [CW-1:0] rx_cnt_reg;

	logic          apb_done;
	logic          wr;
	logic          rd;
	logic [CW-1:0] cap;
	logic          tx_full;
	logic          rx_full;
	logic          rx_empty;
	logic          tx_push;
	logic          tx_pop;
	logic          rx_push;
	logic          rx_pop;
	logic          ovf_evt;
	logic          buf_evt;
	logic [1:0]    ista_set;
	logic [1:0]    ista_clr;
	logic [15:0]   stat_word;
	logic [31:0]   rd_mux;
	logic          mapped;

	spsb_word_type load;
	logic          load_ready;
	logic          loaded;
	logic          word_done;
	logic [W-1:0]  rx_word;
	spsb_link_type link_in;

	// ----------------------------------------------------------------
	// Shifter
	// ----------------------------------------------------------------
	assign link_in = '{sck: sck, sdi: sdi, ss_n: ss_n};
	assign load    = '{valid: tx_cnt_reg != '0, data: tx_mem[tx_rp_reg]};

	spsb_shift_engine #(
		.W (W)
	) u_engine (
		.pclk       (pclk),
		.presetn    (presetn),
		.enable     (en_reg),
		.link_in    (link_in),
		.load       (load),
		.load_ready (load_ready),
		.loaded     (loaded),
		.word_done  (word_done),
		.rx_word    (rx_word),
		.sdo        (sdo),
		.sdo_oe     (sdo_oe)
	);

	// ----------------------------------------------------------------
	// Buffer flags
	// ----------------------------------------------------------------
	assign apb_done = psel & penable & pready;
	assign wr       = apb_done & pwrite;
	assign rd       = apb_done & ~pwrite;

	assign cap      = enh_reg ? CW'(DEPTH) : CW'(1);
	assign tx_full  = (tx_cnt_reg >= cap);
	assign rx_full  = (rx_cnt_reg >= cap);
	assign rx_empty = (rx_cnt_reg == '0);

	assign tx_push  = wr & hit(DATA_OFF) & ~tx_full & en_reg;
	assign tx_pop   = load.valid & load_ready;
	assign rx_push  = word_done & ~rx_full;
	assign ovf_evt  = word_done & rx_full;
	assign rx_pop   = rd & hit(DATA_OFF) & ~rx_empty;

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp_reg  <= '0;
			tx_rp_reg  <= '0;
			tx_cnt_reg <= '0;
		end else if (!en_reg) begin
			tx_wp_reg  <= '0;
			tx_rp_reg  <= '0;
			tx_cnt_reg <= '0;
		end else begin
			if (tx_push)
				tx_wp_reg <= ptr_inc(tx_wp_reg);
			if (tx_pop)
				tx_rp_reg <= ptr_inc(tx_rp_reg);
			tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
		end
	end

	always_ff @(posedge pclk) begin
		if (tx_push)
			tx_mem[tx_wp_reg] <= pwdata[W-1:0];
	end

	// ----------------------------------------------------------------
	// Receive FIFO
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp_reg  <= '0;
			rx_rp_reg  <= '0;
			rx_cnt_reg <= '0;
		end else if (!en_reg) begin
			rx_wp_reg  <= '0;
			rx_rp_reg  <= '0;
			rx_cnt_reg <= '0;
		end else begin
			if (rx_push)
				rx_wp_reg <= ptr_inc(rx_wp_reg);
			if (rx_pop)
				rx_rp_reg <= ptr_inc(rx_rp_reg);
			rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
		end
	end

	always_ff @(posedge pclk) begin
		if (rx_push)
			rx_mem[rx_wp_reg] <= rx_word;
	end

	// ----------------------------------------------------------------
	// Buffer interrupt selector
	// ----------------------------------------------------------------
	always_comb begin
		buf_evt = 1'b0;
		unique case (sel_reg)
		SEL_TX_FULL:  buf_evt = tx_full;
		SEL_TX_EMPTY: buf_evt = tx_pop & (tx_cnt_reg == CW'(1));
		SEL_TX_DONE:  buf_evt = word_done;
		SEL_TX_SPOT:  buf_evt = tx_pop;
		SEL_RX_FULL:  buf_evt = rx_full;
		SEL_RX_3Q:    buf_evt = ({rx_cnt_reg, 2'b00} >=
		                         ({1'b0, cap, 1'b0} + {2'b00, cap}));
		SEL_RX_AVAIL: buf_evt = ~rx_empty;
		SEL_RX_READ:  buf_evt = rx_pop & (rx_cnt_reg == CW'(1));
		endcase
	end

	// ----------------------------------------------------------------
	// Control and status registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg   <= 1'b0;
			sel_reg  <= SEL_RESET;
			enh_reg  <= 1'b0;
			imsk_reg <= MASK_RESET;
		end else if (wr) begin
			if (hit(STAT_OFF)) begin
				en_reg  <= pwdata[EN_BIT];
				sel_reg <= pwdata[SEL_LSB +: 3];
			end
			if (hit(CTRL_OFF))
				enh_reg <= pwdata[ENH_BIT];
			if (hit(IMSK_OFF))
				imsk_reg <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rov_reg <= 1'b0;
		else if (ovf_evt)
			rov_reg <= 1'b1;
		else if (wr && hit(STAT_OFF) && pwdata[ROV_BIT])
			rov_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Interrupt status and output
	// ----------------------------------------------------------------
	assign ista_set = {ovf_evt, buf_evt};
	assign ista_clr = (wr && hit(ISTA_OFF)) ? pwdata[1:0] : 2'b00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ista_reg <= 2'b00;
			irq      <= 1'b0;
		end else begin
			ista_reg <= (ista_reg & ~ista_clr) | ista_set;
			irq      <= |(ista_reg & imsk_reg);
		end
	end

	// ----------------------------------------------------------------
	// APB read path
	// ----------------------------------------------------------------
	always_comb begin
		stat_word                     = 16'h0000;
		stat_word[EN_BIT]             = en_reg;
		stat_word[CNT_LSB +: CNT_W]   = CNT_W'(tx_cnt_reg);
		stat_word[SR_MT_BIT]          = ~loaded;
		stat_word[ROV_BIT]            = rov_reg;
		stat_word[RX_MT_BIT]          = rx_empty;
		stat_word[SEL_LSB +: 3]       = sel_reg;
		stat_word[TBF_BIT]            = tx_full;
		stat_word[RBF_BIT]            = rx_full;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		mapped = 1'b1;
		unique case (paddr)
		STAT_OFF: rd_mux = {16'h0000, stat_word};
		CTRL_OFF: rd_mux = {31'h0000_0000, enh_reg};
		DATA_OFF: rd_mux = rx_empty ? 32'h0000_0000 :
		                   {{(32-W){1'b0}}, rx_mem[rx_rp_reg]};
		ISTA_OFF: rd_mux = {30'h0000_0000, ista_reg};
		IMSK_OFF: rd_mux = {30'h0000_0000, imsk_reg};
		default:  mapped = 1'b0;
		endcase
	end

	// No wait state: answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~mapped;
			if (psel && !penable)
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

endmodule
`default_nettype wire

// *** rtl/spsb_shift_engine.sv ***
// Bit shifter facing the serial link, clocked by pclk
`timescale 1ns/1ps
`default_nettype none
module spsb_shift_engine
	import spsb_pkg::*;
#(
	parameter int W = WORD_W
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          enable,
	input  wire spsb_link_type link_in,
	input  wire spsb_word_type load,
	output logic               load_ready,
	output logic               loaded,
	output logic               word_done,
	output logic [W-1:0]       rx_word,
	output logic               sdo,
	output logic               sdo_oe
);

	spsb_link_type    s1_reg;
	spsb_link_type    s2_reg;
	logic             sck_d_reg;
	spsb_eng_type     st_reg;
	logic [W-1:0]     tx_reg;
	logic [W-1:0]     rx_reg;
	logic [$clog2(W)-1:0] cnt_reg;
	logic             rise;
	logic             fall;
	logic             sel;

	// Two-stage pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg    <= '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
			s2_reg    <= '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
			sck_d_reg <= 1'b0;
		end else begin
			s1_reg    <= link_in;
			s2_reg    <= s1_reg;
			sck_d_reg <= s2_reg.sck;
		end
	end

	assign rise = s2_reg.sck & ~sck_d_reg;
	assign fall = ~s2_reg.sck & sck_d_reg;
	assign sel  = enable & ~s2_reg.ss_n;
	assign load_ready = ~loaded & (cnt_reg == '0) & ~rise & enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg    <= ENG_IDLE;
			cnt_reg   <= '0;
			loaded    <= 1'b0;
			word_done <= 1'b0;
			tx_reg    <= '0;
			rx_reg    <= '0;
			rx_word   <= '0;
		end else begin
			word_done <= 1'b0;
			if (load.valid && load_ready) begin
				tx_reg <= load.data;
				loaded <= 1'b1;
			end
			unique case (st_reg)
			ENG_IDLE: begin
				cnt_reg <= '0;
				if (sel)
					st_reg <= ENG_SHIFT;
			end
			ENG_SHIFT: begin
				if (!sel) begin
					st_reg  <= ENG_IDLE;
					cnt_reg <= '0;
				end else if (rise) begin
					rx_reg  <= {rx_reg[W-2:0], s2_reg.sdi};
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == ($clog2(W))'(W-1)) begin
						word_done <= 1'b1;
						rx_word   <= {rx_reg[W-2:0], s2_reg.sdi};
						loaded    <= 1'b0;
						cnt_reg   <= '0;
					end
				end else if (fall && cnt_reg != '0) begin
					tx_reg <= {tx_reg[W-2:0], 1'b0};
				end
			end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo    <= tx_reg[W-1];
			sdo_oe <= sel;
		end
	end

endmodule
`default_nettype wire

// *** testbench/serial_port_buffer_status_tb_top.sv ***
// Self-checking bench of the serial port block
`timescale 1ns/1ps
`default_nettype none
module serial_port_buffer_status_tb_top
	import spsb_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready;
	logic              pslverr, sck, sdi, ss_n, sdo, sdo_oe, irq, rerr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rdat;
	logic [7:0]        got;
	logic [7:0]        w [5];
	logic [7:0]        e [4];
	int                errors, cmp_count;
	int                seed = 32'h8ca1ef15;

	spsb_port #(.DEPTH(FIFO_DEPTH), .W(WORD_W)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck(sck), .sdi(sdi),
		.ss_n(ss_n), .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq)
	);

	spsb_link_master lm (
		.sck(sck), .sdi(sdi), .ss_n(ss_n), .sdo(sdo), .sdo_oe(sdo_oe)
	);

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	// ---------------------------------------------
	// Bus, compare and closing tasks
	// ---------------------------------------------
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task automatic test_done();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] sel);
		return (32'h1 << EN_BIT) | (32'(sel) << SEL_LSB);
	endfunction

	function automatic logic q3(input int n);
		return n * 4 >= FIFO_DEPTH * 3;
	endfunction

	task automatic xchg(input int i);
		e[i] = 8'($random(seed));
		lm.xfer(e[i], got);
		@(posedge pclk);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		test_done();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(0, STAT_OFF, 0); chk(rdat, 32'h00a0);
		apb(0, 12'h014, 0); chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
		apb(1, IMSK_OFF, 32'h3);
		apb(1, STAT_OFF, ctl(SEL_TX_FULL));
		w[0] = 8'($random(seed));
		w[1] = 8'($random(seed));
		apb(1, DATA_OFF, w[0]);
		apb(1, DATA_OFF, w[1]);
		apb(1, DATA_OFF, 32'h3c);
		apb(0, STAT_OFF, 0); chk(rdat[TBF_BIT], 1'h1);
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], 1'h1);
		chk(irq, 1'h1);
		apb(1, STAT_OFF, ctl(SEL_TX_DONE));
		apb(1, ISTA_OFF, 32'h3);
		xchg(0); chk(got, w[0]);
		apb(0, STAT_OFF, 0); chk(rdat[1:0], 2'h1);
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], 1'h1);
		apb(1, STAT_OFF, ctl(SEL_RX_FULL));
		apb(1, ISTA_OFF, 32'h3);
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], 1'h1);
		xchg(1); chk(got, w[1]);
		apb(0, DATA_OFF, 0); chk(rdat, e[0]);
		apb(0, DATA_OFF, 0); chk(rdat, 32'h0);
		apb(0, STAT_OFF, 0);
		chk(rdat[ROV_BIT:RBF_BIT], {2'h3, SEL_RX_FULL, 2'h0});
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_OVF], 1'h1);
		apb(1, STAT_OFF, 32'h0040);
		apb(0, STAT_OFF, 0); chk(rdat[ROV_BIT], 1'h0);
		apb(1, CTRL_OFF, 32'h1);
		apb(1, STAT_OFF, ctl(SEL_TX_SPOT));
		apb(1, ISTA_OFF, 32'h3);
		for (int i = 0; i < 5; i++) begin
			w[i] = 8'($random(seed));
			apb(1, DATA_OFF, w[i]);
			apb(0, STAT_OFF, 0); chk(rdat[TBF_BIT], i == FIFO_DEPTH);
		end
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], 1'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1, STAT_OFF, ctl(i == 3 ? SEL_TX_EMPTY : SEL_RX_3Q));
			apb(1, ISTA_OFF, 32'h3);
			xchg(i); chk(got, w[i]);
			apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], i == 3 || q3(i + 1));
			apb(0, STAT_OFF, 0); chk(rdat[1:0], {1'h0, i == 3});
		end
		apb(0, DATA_OFF, 0); chk(rdat, e[0]);
		apb(0, STAT_OFF, 0); chk(rdat[RBF_BIT], 1'h0);
		apb(1, STAT_OFF, ctl(SEL_RX_AVAIL));
		apb(1, ISTA_OFF, 32'h3);
		apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], 1'h1);
		apb(1, STAT_OFF, ctl(SEL_RX_READ));
		apb(1, ISTA_OFF, 32'h3);
		for (int i = 1; i < 4; i++) begin
			apb(0, DATA_OFF, 0); chk(rdat, e[i]);
			apb(0, ISTA_OFF, 0); chk(rdat[IRQ_BUF], i == 3);
		end
		apb(0, STAT_OFF, 0); chk(rdat[RX_MT_BIT], 1'h1);
		chk(irq, 1'h1);
		apb(1, IMSK_OFF, 32'h0);
		@(posedge pclk);
		chk(irq, 1'h0);
		test_done();
	end
endmodule
`default_nettype wire

// *** testbench/spsb_link_master.sv ***
// Serial link master model facing the port's link pins
`timescale 1ns/1ps
`default_nettype none
module spsb_link_master (
	output logic     sck,
	output logic     sdi,
	output logic     ss_n,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	initial begin
		sck = 1'h0;
		sdi = 1'h0;
		ss_n = 1'h1;
	end

	// ---------------------------------------------
	// One framed byte, clock idles low, MSB first
	// ---------------------------------------------
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#1 ss_n = 1'h0;
		#300;
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			#62.5 sck = 1'h1;
			rx[i] = sdo;
			#62.5 sck = 1'h0;
		end
		#100 ss_n = 1'h1;
		// Released line shows no stale bit
		sdi = ~sdi;
	endtask
endmodule
`default_nettype wire

// *** testbench/spsb_port_asserts.sv ***
// Assertions on the ports of the serial port block
`timescale 1ns/1ps
`default_nettype none
module spsb_port_asserts
	import spsb_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int W     = WORD_W
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              ss_n,
	input wire logic              sdo_oe,
	input wire logic              irq
);
	logic       en_q;
	logic [1:0] msk_q;
	logic       wr_done;
	logic       setup;
	logic       map;

	assign wr_done = psel && penable && pready && pwrite;
	assign setup = psel && !penable;
	assign map = paddr inside {STAT_OFF, CTRL_OFF, DATA_OFF, ISTA_OFF, IMSK_OFF};

	// ---------------------------------------------
	// Shadows of enable and mask
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_q <= 1'h0;
		else if (wr_done && paddr == STAT_OFF)
			en_q <= pwdata[EN_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			msk_q <= 2'h0;
		else if (wr_done && paddr == IMSK_OFF)
			msk_q <= pwdata[1:0];
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	setup_ready_a: assert property (setup |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	mapped_ok_a: assert property (pready && map |-> !pslverr)
		else $error("error on mapped address");
	bad_zero_a: assert property (pready && !map |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	rdata_hold_a: assert property (!$past(setup) |-> $stable(prdata))
		else $error("read data moved outside setup");
	data_upper_a: assert property (pready && !pwrite && paddr == DATA_OFF
		|-> prdata[31:W] == '0)
		else $error("data read upper bits set");
	select_idle_a: assert property (ss_n [*5] |-> !sdo_oe)
		else $error("driving while deselected");
	port_off_a: assert property (!en_q [*5] |-> !sdo_oe)
		else $error("driving while disabled");
	irq_mask_a: assert property ((msk_q == 2'h0) [*2] |-> !irq)
		else $error("interrupt while all masked");
endmodule

bind spsb_port spsb_port_asserts #(.DEPTH(DEPTH), .W(W)) u_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ss_n(ss_n), .sdo_oe(sdo_oe),
	.irq(irq)
);
`default_nettype wire
